// ==== inc/mdfl_pkg.sv ====
// Constants for the multidrop ASCII frame link
package mdfl_pkg;

   // ****************************************
   // Control characters
   // ****************************************
   localparam logic [7:0] CH_STX  = 8'h02;
   localparam logic [7:0] CH_ETX  = 8'h03;
   localparam logic [7:0] CH_ETB  = 8'h17;
   localparam logic [7:0] CH_ACK  = 8'h06;
   localparam logic [7:0] CH_NAK  = 8'h15;
   localparam logic [7:0] CH_NETID = 8'h40;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_HASH = 8'h23;
   localparam logic [7:0] CH_BANG = 8'h21;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_ONE  = 8'h31;

   // ****************************************
   // Check character and limits
   // ****************************************
   localparam logic [7:0] LRC_PRESET   = 8'hFF;
   localparam logic [7:0] MSG_MAX      = 8'hFF;
   localparam logic [1:0] BNUM_LAST    = 2'h2;
   localparam logic [2:0] RESEND_MAX   = 3'h5;
   localparam logic [6:0] STATION_MIN  = 7'h01;

   // ****************************************
   // Reply and result positions
   // ****************************************
   localparam logic [3:0] REPLY_LAST   = 4'h2;
   localparam logic [3:0] RES_LRC_IDX  = 4'h3;
   localparam logic [3:0] RES_STAT_IDX = 4'h7;
   localparam logic [3:0] RES_OK_END   = 4'h9;
   localparam logic [3:0] RES_ERR_END  = 4'hC;

   // ****************************************
   // Reset values and buffer depth
   // ****************************************
   localparam logic [7:0] CODE_RST  = 8'h00;
   localparam logic [1:0] FILL_RST  = 2'h0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage

// ==== design/mdfl_frame_link.sv ====
// Device-side framer and checker for the multidrop ASCII link
`timescale 1ns/1ns
// Overview of operation
// RULE_01 - Odd-parity check byte closes every block
// RULE_02 - Check accumulator starts at all ones
// RULE_03 - Check covers start, body and end characters
// RULE_04 - Reply ACK or NAK after each block
// RULE_05 - Host resends block after our NAK
// RULE_06 - Resend result on host NAK, five times
// RULE_07 - Host retransmits after two seconds silence
// RULE_08 - Host reports repeated failures as error
// RULE_09 - Block prefix: id char plus station number
// RULE_10 - Station 1..127 hex, act only on ours
// RULE_11 - Order: id, station, STX, number, body, end, check
// RULE_12 - Full non-final block ends with ETB
// RULE_13 - Final block ends with ETX
// RULE_14 - Command opens with space, function code
// RULE_15 - Parameters are signed 16-bit hex text
// RULE_16 - Space and code only in first block
// RULE_17 - Result hash, or bang plus three chars
// RULE_18 - Host keeps one-block parameter under 254
// RULE_19 - Host keeps two-block parameter under 510; code takes at most 508 chars (253 + 255)
// RULE_20 - Execute only after final block acknowledged
// RULE_21 - Host waits for ACK before next block
// RULE_22 - Data values are signed 16-bit hex text
// RULE_23 - Station digits follow every ACK or NAK
// RULE_24 - Bad check byte: NAK and discard block
module mdfl_frame_link (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic [6:0]  station_id,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   output logic             msg_valid,
   output logic [7:0]       msg_data,
   output logic             blk_good,
   output logic             blk_bad,
   output logic [7:0]       cmd_code,
   output logic             cmd_exec,
   input  wire logic        res_valid,
   input  wire logic        res_ok,
   input  wire logic [23:0] res_code,
   output logic             res_ready,
   output logic             link_error
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) begin
         hex_val = {1'b1, c[3:0]};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         hex_val = {1'b1, c[3:0] + 4'h9};
      end else begin
         hex_val = 5'h00;
      end
   endfunction
   function automatic logic [7:0] hex_chr(input logic [3:0] n);
      hex_chr = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction
   // ****************************************
   // States
   // ****************************************
   typedef enum logic [2:0] {
      R_IDLE, R_ST_HI, R_ST_LO, R_STX, R_BNUM, R_MSG, R_LRC
   } mdfl_rx_e;
   typedef enum logic [2:0] {
      C_IDLE, C_REPLY, C_EXEC, C_RESULT, C_WAIT
   } mdfl_ctl_e;
   mdfl_rx_e    rx_q;
   mdfl_ctl_e   ctl_q;
   logic [3:0]  st_hi_q, idx_q;
   logic [7:0]  rx_lrc_q, rcnt_q, tx_lrc_q, seq_byte;
   logic [23:0] res_code_q;
   logic [2:0]  resend_q;
   logic [7:0]  buf_q [0:1];
   logic [1:0]  fill_q;
   logic [4:0]  hv;
   logic        blk_err_q, blk_last_q, first_blk_q, verdict_q;
   logic        verdict_nak_q, reply_nak_q, reply_last_q, res_ok_q;
   logic        rd_ptr_q, seq_valid, push, pop, host_ans;
   assign hv       = hex_val(rx_data);
   assign host_ans = rx_valid && ctl_q == C_WAIT && rx_q == R_IDLE;
   // ****************************************
   // Receive parser
   // ****************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_q        <= R_IDLE;
         st_hi_q     <= 4'h0;
         rx_lrc_q    <= mdfl_pkg::LRC_PRESET;
         rcnt_q      <= 8'h00;
         blk_err_q   <= 1'b0;
         blk_last_q  <= 1'b0;
      end else if (rx_valid) begin
         unique case (rx_q)
            R_IDLE: begin
               if (rx_data == mdfl_pkg::CH_NETID && ctl_q == C_IDLE) begin
                  rx_q <= R_ST_HI; // RULE_09
               end
            end
            R_ST_HI: begin
               st_hi_q <= hv[3:0];
               rx_q    <= (hv[4] && !hv[3]) ? R_ST_LO : R_IDLE; // RULE_10
            end
            R_ST_LO: begin
               if (hv[4] && {st_hi_q[2:0], hv[3:0]} == station_id
                   && station_id >= mdfl_pkg::STATION_MIN) begin
                  rx_q <= R_STX; // RULE_10
               end else begin
                  rx_q <= R_IDLE;
               end
            end
            R_STX: begin
               rx_lrc_q  <= mdfl_pkg::LRC_PRESET ^ rx_data; // RULE_02
               rcnt_q    <= 8'h00;
               blk_err_q <= 1'b0;
               rx_q <= (rx_data == mdfl_pkg::CH_STX) ? R_BNUM : R_IDLE;
            end
            R_BNUM: begin
               rx_lrc_q <= rx_lrc_q ^ rx_data; // RULE_03
               rcnt_q   <= rcnt_q + 8'h01;
               if (!hv[4] || hv[3:0] > 4'h9) begin
                  blk_err_q <= 1'b1; // RULE_11
               end
               if (rcnt_q[1:0] == mdfl_pkg::BNUM_LAST) begin
                  rcnt_q <= 8'h00;
                  rx_q   <= R_MSG;
               end
            end
            R_MSG: begin
               rx_lrc_q <= rx_lrc_q ^ rx_data; // RULE_03
               if (rx_data == mdfl_pkg::CH_ETX) begin
                  blk_last_q <= 1'b1; // RULE_13
                  rx_q       <= R_LRC;
               end else if (rx_data == mdfl_pkg::CH_ETB) begin
                  blk_last_q <= 1'b0;
                  if (rcnt_q != mdfl_pkg::MSG_MAX) begin
                     blk_err_q <= 1'b1; // RULE_12
                  end
                  rx_q <= R_LRC;
               end else if (rcnt_q == mdfl_pkg::MSG_MAX) begin
                  blk_err_q <= 1'b1; // RULE_11
               end else begin
                  rcnt_q <= rcnt_q + 8'h01;
               end
            end
            R_LRC:   rx_q <= R_IDLE; // RULE_01
            default: rx_q <= R_IDLE;
         endcase
      end
   end
   // Block verdict, one pulse after the check byte
   always_ff @(posedge mclk) begin
      if (srst) begin
         verdict_q     <= 1'b0;
         verdict_nak_q <= 1'b0;
      end else begin
         verdict_q     <= rx_valid && rx_q == R_LRC;
         verdict_nak_q <= blk_err_q || rx_data != rx_lrc_q; // RULE_24
      end
   end
   // ****************************************
   // Message delivery
   // ****************************************
   // Characters go out as they arrive; a bad verdict tells the user
   // to drop them, which avoids a 255-byte holding store.
   always_ff @(posedge mclk) begin
      if (srst) begin
         msg_valid <= 1'b0;
         msg_data  <= 8'h00;
         cmd_code  <= mdfl_pkg::CODE_RST;
      end else begin
         msg_valid <= 1'b0;
         if (rx_valid && rx_q == R_MSG && rx_data != mdfl_pkg::CH_ETX
             && rx_data != mdfl_pkg::CH_ETB) begin
            if (first_blk_q && rcnt_q == 8'h01) begin
               cmd_code <= rx_data; // RULE_14
            end else if (!(first_blk_q && rcnt_q == 8'h00
                           && rx_data == mdfl_pkg::CH_SPACE)) begin
               msg_valid <= 1'b1; // RULE_16
               msg_data  <= rx_data; // RULE_15 RULE_22
            end
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         blk_good    <= 1'b0;
         blk_bad     <= 1'b0;
         first_blk_q <= 1'b1;
      end else begin
         blk_good <= verdict_q && !verdict_nak_q;
         blk_bad  <= verdict_q && verdict_nak_q; // RULE_24
         if (verdict_q && !verdict_nak_q) begin
            first_blk_q <= blk_last_q; // RULE_16
         end
      end
   end
   // ****************************************
   // Reply and result sequencer
   // ****************************************
   always_comb begin
      seq_byte  = 8'h00;
      seq_valid = ctl_q == C_REPLY || ctl_q == C_RESULT;
      if (ctl_q == C_REPLY) begin
         unique case (idx_q)
            4'h0:    seq_byte = reply_nak_q ? mdfl_pkg::CH_NAK
                                            : mdfl_pkg::CH_ACK; // RULE_04
            4'h1:    seq_byte = hex_chr({1'b0, station_id[6:4]}); // RULE_23
            default: seq_byte = hex_chr(station_id[3:0]); // RULE_23
         endcase
      end else begin
         unique case (idx_q)
            4'h0:    seq_byte = mdfl_pkg::CH_NETID; // RULE_09
            4'h1:    seq_byte = hex_chr({1'b0, station_id[6:4]});
            4'h2:    seq_byte = hex_chr(station_id[3:0]);
            4'h3:    seq_byte = mdfl_pkg::CH_STX; // RULE_11
            4'h4:    seq_byte = mdfl_pkg::CH_ZERO;
            4'h5:    seq_byte = mdfl_pkg::CH_ZERO;
            4'h6:    seq_byte = mdfl_pkg::CH_ONE;
            4'h7:    seq_byte = res_ok_q ? mdfl_pkg::CH_HASH
                                         : mdfl_pkg::CH_BANG; // RULE_17
            4'h8:    seq_byte = res_ok_q ? mdfl_pkg::CH_ETX
                                         : res_code_q[23:16];
            4'h9:    seq_byte = res_ok_q ? tx_lrc_q : res_code_q[15:8];
            4'hA:    seq_byte = res_code_q[7:0];
            4'hB:    seq_byte = mdfl_pkg::CH_ETX; // RULE_13
            default: seq_byte = tx_lrc_q; // RULE_01
         endcase
      end
   end
   assign push      = seq_valid && fill_q != mdfl_pkg::BUF_DEPTH;
   assign res_ready = ctl_q == C_EXEC;
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctl_q        <= C_IDLE;
         reply_nak_q  <= 1'b0;
         reply_last_q <= 1'b0;
         idx_q        <= 4'h0;
         tx_lrc_q     <= mdfl_pkg::LRC_PRESET;
         res_ok_q     <= 1'b0;
         res_code_q   <= 24'h000000;
         resend_q     <= 3'h0;
         cmd_exec     <= 1'b0;
         link_error   <= 1'b0;
      end else begin
         cmd_exec   <= 1'b0;
         link_error <= 1'b0;
         if (push) begin
            idx_q <= idx_q + 4'h1;
            if (ctl_q == C_RESULT && idx_q >= mdfl_pkg::RES_LRC_IDX) begin
               tx_lrc_q <= tx_lrc_q ^ seq_byte; // RULE_03
            end
         end
         unique case (ctl_q)
            C_IDLE: begin
               if (verdict_q) begin
                  reply_nak_q  <= verdict_nak_q; // RULE_24
                  reply_last_q <= blk_last_q;
                  idx_q        <= 4'h0;
                  ctl_q        <= C_REPLY; // RULE_04
               end
            end
            C_REPLY: begin
               if (push && idx_q == mdfl_pkg::REPLY_LAST) begin
                  if (!reply_nak_q && reply_last_q) begin
                     cmd_exec <= 1'b1; // RULE_20
                     ctl_q    <= C_EXEC;
                  end else begin
                     ctl_q <= C_IDLE;
                  end
               end
            end
            C_EXEC: begin
               if (res_valid) begin
                  res_ok_q   <= res_ok;
                  res_code_q <= res_code; // RULE_17
                  resend_q   <= 3'h0;
                  idx_q      <= 4'h0;
                  tx_lrc_q   <= mdfl_pkg::LRC_PRESET; // RULE_02
                  ctl_q      <= C_RESULT;
               end
            end
            C_RESULT: begin
               if (push && idx_q == (res_ok_q ? mdfl_pkg::RES_OK_END
                                              : mdfl_pkg::RES_ERR_END)) begin
                  ctl_q <= C_WAIT;
               end
            end
            C_WAIT: begin
               if (host_ans && rx_data == mdfl_pkg::CH_ACK) begin
                  ctl_q <= C_IDLE;
               end else if (host_ans && rx_data == mdfl_pkg::CH_NAK) begin
                  if (resend_q < mdfl_pkg::RESEND_MAX) begin
                     resend_q <= resend_q + 3'h1; // RULE_06
                     idx_q    <= 4'h0;
                     tx_lrc_q <= mdfl_pkg::LRC_PRESET;
                     ctl_q    <= C_RESULT;
                  end else begin
                     link_error <= 1'b1; // RULE_06
                     ctl_q      <= C_IDLE;
                  end
               end
            end
            default: ctl_q <= C_IDLE;
         endcase
      end
   end
   // ****************************************
   // Two-entry transmit buffer
   // ****************************************
   // A stalled transmitter fills it and then holds the sequencer.
   assign tx_valid = fill_q != mdfl_pkg::FILL_RST;
   assign tx_data  = buf_q[rd_ptr_q];
   assign pop      = tx_valid && tx_ready;
   always_ff @(posedge mclk) begin
      if (srst) begin
         fill_q   <= mdfl_pkg::FILL_RST;
         rd_ptr_q <= 1'b0;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
      end else begin
         if (push) begin
            buf_q[rd_ptr_q ^ fill_q[0]] <= seq_byte;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // mdfl_frame_link

// ==== verif/mdfl_frame_link_props.sv ====
// Port checker for the multidrop frame link
`timescale 1ns/1ns
module mdfl_frame_link_props (
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_ready,
   input wire logic       msg_valid,
   input wire logic [7:0] msg_data,
   input wire logic       blk_good,
   input wire logic       blk_bad,
   input wire logic       cmd_exec,
   input wire logic       res_valid,
   input wire logic       res_ready,
   input wire logic       link_error
);
   // ****************************************
   // Port relations
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Stall must not lose or swap a byte
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("tx byte moved during stall");
   property p_ack;
      blk_good |-> ##[1:8] (tx_valid && tx_data == mdfl_pkg::CH_ACK);
   endproperty
   a_ack: assert property (p_ack)
      else $error("no ACK after good block");
   property p_nak;
      blk_bad |-> ##[1:8] (tx_valid && tx_data == mdfl_pkg::CH_NAK);
   endproperty
   a_nak: assert property (p_nak)
      else $error("no NAK after bad block");
   // Verdict only two cycles after a received byte, never both kinds
   property p_excl;
      blk_good || blk_bad |-> $past(rx_valid, 2) && !(blk_good && blk_bad);
   endproperty
   a_excl: assert property (p_excl)
      else $error("verdict without check byte or doubled");
   property p_msg;
      msg_valid |-> $past(rx_valid) && msg_data == $past(rx_data);
   endproperty
   a_msg: assert property (p_msg)
      else $error("message char not from last rx byte");
   property p_exec;
      cmd_exec |-> ##[0:1] res_ready ##1 !cmd_exec;
   endproperty
   a_exec: assert property (p_exec)
      else $error("exec without result wait");
   property p_take;
      res_valid && res_ready |=> !res_ready ##[0:12]
         (tx_valid && tx_data == mdfl_pkg::CH_NETID);
   endproperty
   a_take: assert property (p_take)
      else $error("result block not opened by id char");
   property p_lerr;
      link_error |-> !tx_valid ##1 !link_error;
   endproperty
   a_lerr: assert property (p_lerr)
      else $error("link error not a quiet pulse");
endmodule // mdfl_frame_link_props

bind mdfl_frame_link mdfl_frame_link_props mdfl_frame_link_props_i (
   .mclk(mclk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
   .msg_valid(msg_valid), .msg_data(msg_data), .blk_good(blk_good),
   .blk_bad(blk_bad), .cmd_exec(cmd_exec), .res_valid(res_valid),
   .res_ready(res_ready), .link_error(link_error)
);

// ==== verif/mdfl_host_model.sv ====
// Host model: sends byte strings, drains replies with stalls
`timescale 1ns/1ns
module mdfl_host_model (
   input  wire logic       mclk,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   input  wire logic       slow
);
   // ****************************************
   // Reply drain and block sender
   // ****************************************
   logic [7:0] txq[$];
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   always @(negedge mclk) tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
   always @(posedge mclk) begin
      if (tx_valid && tx_ready) txq.push_back(tx_data);
   end
   // Next block only sent by caller after full reply seen
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) begin
         @(negedge mclk);
         rx_valid <= 1'b1;
         rx_data <= q[i];
      end
      @(negedge mclk);
      rx_valid <= 1'b0;
      // Released line must not show the last byte
      rx_data <= ~rx_data;
   endtask
endmodule // mdfl_host_model

// ==== verif/mdfl_frame_link_bench.sv ====
// Self-checking bench for the multidrop frame link
`timescale 1ns/1ns
module mdfl_frame_link_bench;
   typedef logic [7:0] mdfl_bq_t[$];
   logic        mclk, srst, rx_valid, tx_valid, tx_ready, msg_valid;
   logic        blk_good, blk_bad, cmd_exec, res_valid, res_ok;
   logic        res_ready, link_error, slow;
   logic [6:0]  st;
   logic [7:0]  rx_data, tx_data, msg_data, cmd_code, fc;
   logic [23:0] res_code;
   int          fail_count, samples_checked, cyc, n_exec, n_lerr, e;
   mdfl_bq_t    msgq, p, q, rb;

   mdfl_frame_link mdfl_frame_link_i (
      .mclk(mclk), .srst(srst), .station_id(st), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .msg_valid(msg_valid), .msg_data(msg_data),
      .blk_good(blk_good), .blk_bad(blk_bad), .cmd_code(cmd_code),
      .cmd_exec(cmd_exec), .res_valid(res_valid), .res_ok(res_ok),
      .res_code(res_code), .res_ready(res_ready), .link_error(link_error)
   );
   mdfl_host_model host_i (
      .mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .slow(slow)
   );

   // ****************************************
   // Clock, monitors, timeout
   // ****************************************
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      if (msg_valid) msgq.push_back(msg_data);
      if (cmd_exec) n_exec++;
      if (link_error) n_lerr++;
      cyc++;
      // Generous ceiling: the whole run needs well under a thousand cycles
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ****************************************
   // Expectation helpers
   // ****************************************
   function automatic logic [7:0] hx(logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction
   function automatic mdfl_bq_t rbody(int n);
      mdfl_bq_t r;
      repeat (n) r.push_back(hx(4'($urandom_range(0, 15))));
      return r;
   endfunction
   function automatic mdfl_bq_t rply(logic [7:0] c);
      return {c, hx({1'b0, st[6:4]}), hx(st[3:0])};
   endfunction
   // Check byte starts at STX; id and station stay outside it
   function automatic mdfl_bq_t mk_blk(logic [6:0] s, logic [7:0] bn,
         mdfl_bq_t b, logic [7:0] ec, logic [7:0] flip);
      mdfl_bq_t r;
      logic [7:0] l;
      r = {8'h40, hx({1'b0, s[6:4]}), hx(s[3:0]), 8'h02, 8'h30, 8'h30, bn};
      r = {r, b, ec};
      l = 8'hFF;
      for (int i = 3; i < r.size(); i++) l ^= r[i];
      return {r, l ^ flip};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic chk_q(input mdfl_bq_t g, input mdfl_bq_t x);
      chk(g.size(), x.size());
      if (g.size() == x.size()) foreach (x[i]) chk(g[i], x[i]);
   endtask
   task automatic expect_tx(input mdfl_bq_t x);
      int n;
      n = 0;
      while (host_i.txq.size() < x.size() && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      chk_q(host_i.txq, x);
      host_i.txq.delete();
   endtask
   task automatic give_res(input logic ok, input logic [23:0] code);
      int n;
      n = 0;
      @(negedge mclk);
      res_valid = 1'b1;
      res_ok = ok;
      res_code = code;
      while (!res_ready && n < 500) begin
         @(negedge mclk);
         n++;
      end
      chk(res_ready, 1'b1);
      @(negedge mclk);
      res_valid = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      mclk = 1'b0;
      srst = 1'b1;
      res_valid = 1'b0;
      res_ok = 1'b0;
      res_code = 24'h000000;
      slow = 1'b0;
      void'($urandom(48));
      st = 7'($urandom_range(1, 127));
      fc = 8'($urandom_range(65, 90));
      repeat (3) @(negedge mclk);
      chk({tx_valid, res_ready, cmd_code}, 32'h0);
      srst = 1'b0;
      host_i.send(mk_blk(7'(st % 127 + 1), 8'h31, {8'h20, fc}, 8'h03, 8'h00));
      repeat (60) @(negedge mclk);
      chk(host_i.txq.size(), 0);
      p = rbody(4);
      q = mk_blk(st, 8'h31, {8'h20, fc, p}, 8'h03, 8'h00);
      host_i.send(mk_blk(st, 8'h31, {8'h20, fc, p}, 8'h03, 8'h01));
      expect_tx(rply(8'h15));
      host_i.send(q);
      expect_tx(rply(8'h06));
      chk(cmd_code, fc);
      give_res(1'b1, 24'h000000);
      expect_tx(mk_blk(st, 8'h31, {8'h23}, 8'h03, 8'h00));
      host_i.send(rply(8'h06));
      host_i.send(mk_blk(st, 8'h31, rbody(10), 8'h17, 8'h00));
      expect_tx(rply(8'h15));
      slow = 1'b1;
      repeat (10) @(negedge mclk);
      msgq.delete();
      e = n_exec;
      p = rbody(253);
      host_i.send(mk_blk(st, 8'h31, {8'h20, fc, p}, 8'h17, 8'h00));
      expect_tx(rply(8'h06));
      chk(n_exec, e);
      q = rbody(3);
      host_i.send(mk_blk(st, 8'h32, q, 8'h03, 8'h00));
      expect_tx(rply(8'h06));
      repeat (4) @(negedge mclk);
      chk(n_exec, e + 1);
      chk_q(msgq, {p, q});
      rb = mk_blk(st, 8'h31, {8'h21, 8'h45, 8'h31, 8'h32}, 8'h03, 8'h00);
      give_res(1'b0, 24'h453132);
      expect_tx(rb);
      for (int k = 0; k < 5; k++) begin
         host_i.send(rply(8'h15));
         expect_tx(rb);
      end
      host_i.send(rply(8'h15));
      repeat (20) @(negedge mclk);
      chk(n_lerr, 1);
      chk(host_i.txq.size(), 0);
      tally_and_finish();
   end
endmodule // mdfl_frame_link_bench
